// ### pkg/bst_pkg.sv
// Constants, types and register map for the line coder timing block.
// Contract
// - Squelch asserts when three line edges fall within assert window times four plus one.
// - Receive path stays open for hold window times four plus one cycles.
// - Squelch drop comes from the maximum high and low bit time limits.
// - Every transmitted bit, the last included, lasts bit period count plus one cycles.
// - Line reported active when three transitions arrive within one idle window.
// - Line reported idle when a full idle window passes without three transitions.
// - Idle window lasts exactly idle window register times four system clocks.
// - The four timing fields are 8-bit read/write values resetting to zero.
package bst_pkg;
  localparam int          REG_W         = 8;
  localparam int          NREG          = 4;
  localparam int          TMR_W         = 10;
  localparam int          WIN_SHIFT     = 2;
  localparam int          RI_SQ_ASSERT  = 0;
  localparam int          RI_SQ_HOLD    = 1;
  localparam int          RI_TX_PERIOD  = 2;
  localparam int          RI_IDLE_WIN   = 3;
  localparam logic [15:0] IDX_SQ_ASSERT = 16'h1AA8;
  localparam logic [15:0] IDX_SQ_HOLD   = 16'h1AA9;
  localparam logic [15:0] IDX_TX_PERIOD = 16'h1AB0;
  localparam logic [15:0] IDX_IDLE_WIN  = 16'h1AB1;
  localparam logic [15:0] REG_ADDR [NREG] = '{
    {IDX_SQ_ASSERT[13:0], 2'h0},
    {IDX_SQ_HOLD[13:0], 2'h0},
    {IDX_TX_PERIOD[13:0], 2'h0},
    {IDX_IDLE_WIN[13:0], 2'h0}
  };
  localparam logic [7:0]  REG_RST       = 8'h00;
  localparam logic [9:0]  WIN_EXTRA     = 10'h001;
  localparam logic [1:0]  EDGES_NEEDED  = 2'h3;
  localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;
  typedef enum logic [1:0] {SQ_IDLE, SQ_ARM, SQ_ACTIVE, SQ_HOLD} bst_sq_t;
  typedef enum logic {TX_IDLE, TX_BIT} bst_tx_t;
endpackage

// ### pkg/bst_buf_if.sv
// Valid/ready stream carrying transmit bits into and out of the buffer.
`timescale 1ns/1ns
interface bst_buf_if #(parameter int W = 1);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  modport buf_mp (input in_valid, input in_data, input out_ready,
                  output in_ready, output out_valid, output out_data);
  modport user_mp (output in_valid, output in_data, output out_ready,
                   input in_ready, input out_valid, input out_data);
endinterface

// ### src/bst_skid_buf.sv
// Two-entry buffer with registered ready and valid flags.
`timescale 1ns/1ns
module bst_skid_buf #(
  parameter int W     = 1,
  parameter int DEPTH = 2
) (
  input  wire logic sys_clk,
  input  wire logic nrst,
  bst_buf_if.buf_mp bf
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem_q [DEPTH];
  logic [W-1:0]  mem_d [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          rdy_q, rdy_d, vld_q, vld_d;
  logic          push, pop;

  assign bf.in_ready  = rdy_q;
  assign bf.out_valid = vld_q;
  assign bf.out_data  = mem_q[rp_q];

  always_comb begin
    push  = bf.in_valid && rdy_q;
    pop   = bf.out_ready && vld_q;
    mem_d = mem_q;
    wp_d  = wp_q;
    rp_d  = rp_q;
    if (push) begin
      mem_d[wp_q] = bf.in_data;
      wp_d        = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
    end
    if (pop) begin
      rp_d = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
    end
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    rdy_d = cnt_d < (AW+1)'(DEPTH);
    vld_d = cnt_d != '0;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mem_q <= '{default: '0};
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b0;
      vld_q <= 1'b0;
    end else begin
      mem_q <= mem_d;
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
      vld_q <= vld_d;
    end
  end
endmodule

// ### src/bst_top.sv
// Squelch, idle detection and transmit bit timing with APB registers.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
module bst_top (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_line,
  input  wire logic [7:0]  rx_hi_max_time,
  input  wire logic [7:0]  rx_lo_max_time,
  output logic             squelch_active,
  output logic             rx_path_open,
  output logic             line_active,
  input  wire logic        tx_bit_valid,
  input  wire logic        tx_bit,
  output logic             tx_bit_ready,
  output logic             tx_line,
  output logic             tx_line_oe_n,
  output logic             tx_busy
);
  localparam int RW = bst_pkg::REG_W;
  localparam int TW = bst_pkg::TMR_W;

  ////////////////////////////////////////////////////////////////////////////////
  // Register file behind the APB slave.
  logic [RW-1:0] regs_q [bst_pkg::NREG];
  logic [RW-1:0] regs_d [bst_pkg::NREG];
  logic [31:0]   prdata_q, prdata_d;
  logic          pready_q, pready_d, pslverr_q, pslverr_d;
  logic          hit;
  logic [RW-1:0] rsel;

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  always_comb begin
    regs_d    = regs_q;
    prdata_d  = prdata_q;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    hit       = 1'b0;
    rsel      = bst_pkg::REG_RST;
    for (int i = 0; i < bst_pkg::NREG; i++) begin
      if (paddr == bst_pkg::REG_ADDR[i]) begin
        hit  = 1'b1;
        rsel = regs_q[i];
      end
    end
    if (psel && !penable) begin
      pready_d  = 1'b1;
      pslverr_d = !hit;
      prdata_d  = hit ? {{(32-RW){1'b0}}, rsel} : bst_pkg::RDATA_ZERO;
    end
    if (psel && penable && pready_q && pwrite) begin
      for (int i = 0; i < bst_pkg::NREG; i++) begin
        if (paddr == bst_pkg::REG_ADDR[i]) begin
          regs_d[i] = pwdata[RW-1:0];
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      regs_q    <= '{default: bst_pkg::REG_RST};
      prdata_q  <= bst_pkg::RDATA_ZERO;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      regs_q    <= regs_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Window lengths in system clock cycles.
  logic [TW-1:0] alim, hlim, ilim;
  assign alim = (TW'(regs_q[bst_pkg::RI_SQ_ASSERT]) << bst_pkg::WIN_SHIFT)
                + bst_pkg::WIN_EXTRA;
  assign hlim = (TW'(regs_q[bst_pkg::RI_SQ_HOLD]) << bst_pkg::WIN_SHIFT)
                + bst_pkg::WIN_EXTRA;
  assign ilim = TW'(regs_q[bst_pkg::RI_IDLE_WIN]) << bst_pkg::WIN_SHIFT;

  ////////////////////////////////////////////////////////////////////////////////
  // Receive line synchroniser and edge detection.
  logic [2:0] sync_q, sync_d;
  logic       lvl_q, lvl_d;
  logic       edge_seen;

  always_comb begin
    sync_d    = {sync_q[1:0], rx_line};
    edge_seen = (sync_q[1] == sync_q[2]) && (sync_q[2] != lvl_q);
    lvl_d     = edge_seen ? sync_q[2] : lvl_q;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sync_q <= 3'h0;
      lvl_q  <= 1'b0;
    end else begin
      sync_q <= sync_d;
      lvl_q  <= lvl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Squelch assert, drop and hold.
  bst_pkg::bst_sq_t sq_q, sq_d;
  logic [TW-1:0]    tmr_q, tmr_d;
  logic [1:0]       ecnt_q, ecnt_d;
  logic [RW:0]      gap_q, gap_d;
  logic             sqa_q, sqa_d, open_q, open_d;
  logic [RW:0]      gap_lim;

  assign squelch_active = sqa_q;
  assign rx_path_open   = open_q;

  always_comb begin
    sq_d    = sq_q;
    tmr_d   = tmr_q + 1'b1;
    ecnt_d  = ecnt_q;
    gap_d   = (gap_q == '1) ? gap_q : gap_q + 1'b1;
    gap_lim = {1'b0, lvl_q ? rx_hi_max_time : rx_lo_max_time};
    case (sq_q)
      bst_pkg::SQ_IDLE: begin
        tmr_d  = '0;
        ecnt_d = 2'h0;
        if (edge_seen) begin
          sq_d   = bst_pkg::SQ_ARM;
          ecnt_d = 2'h1;
        end
      end
      bst_pkg::SQ_ARM: begin
        if (edge_seen && ecnt_q + 2'h1 == bst_pkg::EDGES_NEEDED && tmr_q < alim) begin
          sq_d  = bst_pkg::SQ_ACTIVE;
          gap_d = '0;
        end else if (tmr_q + 1'b1 >= alim) begin
          sq_d  = bst_pkg::SQ_IDLE;
        end else if (edge_seen) begin
          ecnt_d = ecnt_q + 2'h1;
        end
      end
      bst_pkg::SQ_ACTIVE: begin
        tmr_d = '0;
        if (edge_seen) begin
          gap_d = '0;
        end else if (gap_q > gap_lim) begin
          sq_d = bst_pkg::SQ_HOLD;
        end
      end
      bst_pkg::SQ_HOLD: begin
        if (edge_seen) begin
          sq_d  = bst_pkg::SQ_ACTIVE;
          gap_d = '0;
        end else if (tmr_q + 1'b1 >= hlim) begin
          sq_d = bst_pkg::SQ_IDLE;
        end
      end
      default: sq_d = bst_pkg::SQ_IDLE;
    endcase
    sqa_d  = (sq_d == bst_pkg::SQ_ACTIVE);
    open_d = (sq_d == bst_pkg::SQ_ACTIVE) || (sq_d == bst_pkg::SQ_HOLD);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sq_q   <= bst_pkg::SQ_IDLE;
      tmr_q  <= '0;
      ecnt_q <= 2'h0;
      gap_q  <= '0;
      sqa_q  <= 1'b0;
      open_q <= 1'b0;
    end else begin
      sq_q   <= sq_d;
      tmr_q  <= tmr_d;
      ecnt_q <= ecnt_d;
      gap_q  <= gap_d;
      sqa_q  <= sqa_d;
      open_q <= open_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Line activity detector.
  logic [TW-1:0] win_q, win_d;
  logic [1:0]    icnt_q, icnt_d;
  logic          act_q, act_d, win_end, third;

  assign line_active = act_q;

  always_comb begin
    act_d   = act_q;
    win_d   = win_q + 1'b1;
    icnt_d  = icnt_q + {1'b0, edge_seen};
    third   = edge_seen && (icnt_q + 2'h1 == bst_pkg::EDGES_NEEDED);
    win_end = (win_q + 1'b1 >= ilim);
    if (third) begin
      act_d  = 1'b1;
      win_d  = '0;
      icnt_d = 2'h0;
    end else if (win_end) begin
      act_d  = 1'b0;
      win_d  = '0;
      icnt_d = {1'b0, edge_seen};
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      win_q  <= '0;
      icnt_q <= 2'h0;
      act_q  <= 1'b0;
    end else begin
      win_q  <= win_d;
      icnt_q <= icnt_d;
      act_q  <= act_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit bit buffer and biphase-mark bit timer.
  bst_buf_if #(.W(1)) bq ();
  bst_pkg::bst_tx_t tx_q, tx_d;
  logic [RW-1:0]    tcnt_q, tcnt_d;
  logic             bit_q, bit_d, line_q, line_d, oe_n_q, oe_n_d, busy_q, busy_d;
  logic             take;
  logic [RW-1:0]    period, half;

  bst_skid_buf #(.W(1), .DEPTH(2)) u_buf (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .bf      (bq.buf_mp)
  );

  assign bq.in_valid   = tx_bit_valid;
  assign bq.in_data    = tx_bit;
  assign bq.out_ready  = take;
  assign tx_bit_ready  = bq.in_ready;
  assign tx_line       = line_q;
  assign tx_line_oe_n  = oe_n_q;
  assign tx_busy       = busy_q;

  always_comb begin
    period = regs_q[bst_pkg::RI_TX_PERIOD];
    half   = period >> 1;
    tx_d   = tx_q;
    tcnt_d = tcnt_q + 1'b1;
    bit_d  = bit_q;
    line_d = line_q;
    oe_n_d = oe_n_q;
    take   = 1'b0;
    case (tx_q)
      bst_pkg::TX_IDLE: begin
        tcnt_d = '0;
        if (bq.out_valid) begin
          take   = 1'b1;
          bit_d  = bq.out_data[0];
          line_d = !line_q;
          oe_n_d = 1'b0;
          tx_d   = bst_pkg::TX_BIT;
        end
      end
      bst_pkg::TX_BIT: begin
        if (tcnt_q == period) begin
          tcnt_d = '0;
          if (bq.out_valid) begin
            take   = 1'b1;
            bit_d  = bq.out_data[0];
            line_d = !line_q;
          end else begin
            tx_d   = bst_pkg::TX_IDLE;
            line_d = 1'b0;
            oe_n_d = 1'b1;
          end
        end else if (bit_q && tcnt_q == half) begin
          line_d = !line_q;
        end
      end
      default: tx_d = bst_pkg::TX_IDLE;
    endcase
    busy_d = (tx_d == bst_pkg::TX_BIT);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_q   <= bst_pkg::TX_IDLE;
      tcnt_q <= '0;
      bit_q  <= 1'b0;
      line_q <= 1'b0;
      oe_n_q <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      tx_q   <= tx_d;
      tcnt_q <= tcnt_d;
      bit_q  <= bit_d;
      line_q <= line_d;
      oe_n_q <= oe_n_d;
      busy_q <= busy_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_third_edge;
    sq_q == bst_pkg::SQ_ARM && edge_seen && ecnt_q == 2'h2 && tmr_q < alim;
  endsequence
  sequence s_hold_run;
    sq_q == bst_pkg::SQ_HOLD && !edge_seen && tmr_q + 1'b1 < hlim;
  endsequence

  AST_SQ_ON: assert property (s_third_edge |=> squelch_active && rx_path_open)
    else $error("Squelch missed the third edge.");
  AST_SQ_ROSE: assert property ($rose(squelch_active) |->
      $past(edge_seen) && $past(sq_q) != bst_pkg::SQ_IDLE)
    else $error("Squelch rose without an edge.");
  AST_HOLD_OPEN: assert property (s_hold_run |=> rx_path_open && !squelch_active)
    else $error("Path closed before the hold ended.");
  AST_HOLD_END: assert property ($fell(rx_path_open) |->
      $past(tmr_q) + 1'b1 >= $past(hlim) && $past(sq_q) == bst_pkg::SQ_HOLD)
    else $error("Path closed at the wrong time.");
  AST_DROP: assert property ($fell(squelch_active) && rx_path_open |->
      $past(gap_q) > $past(gap_lim))
    else $error("Squelch dropped before the bit limit.");
  AST_BIT_LEN: assert property (tx_q == bst_pkg::TX_BIT && take |-> tcnt_q == period)
    else $error("Bit ended at the wrong count.");
  AST_BIT_END: assert property (tx_busy && tcnt_q == period && !bq.out_valid |=>
      !tx_busy && tx_line_oe_n && !tx_line)
    else $error("Last bit not closed properly.");
  AST_ACT_ON: assert property ($rose(line_active) |->
      $past(edge_seen) && $past(icnt_q) == 2'h2)
    else $error("Line active without three transitions.");
  AST_IDLE: assert property ($fell(line_active) |-> $past(win_end) && !$past(third))
    else $error("Line idle before the window ended.");
  AST_WIN: assert property (ilim != '0 && ilim == $past(ilim) &&
      ilim == $past(ilim, 2) |-> win_q < ilim)
    else $error("Idle window ran past its length.");
  AST_REG_WR: assert property (psel && penable && pready && pwrite &&
      paddr == bst_pkg::REG_ADDR[bst_pkg::RI_TX_PERIOD] |=>
      regs_q[bst_pkg::RI_TX_PERIOD] == $past(pwdata[RW-1:0]))
    else $error("Register write lost.");
  AST_RESTART: assert property (sq_q == bst_pkg::SQ_IDLE && edge_seen |=>
      sq_q == bst_pkg::SQ_ARM && tmr_q == '0)
    else $error("Assert timer did not restart.");
endmodule

// ### verif/bst_remote_port.sv
// Behavioural remote port that drives edge bursts onto the received line.
`timescale 1ns/1ns
module bst_remote_port (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        go,
  input  wire logic [3:0]  n_edges,
  input  wire logic [15:0] gap,
  output logic             rx_line,
  output logic             busy
);
  logic [3:0]  left_q;
  logic [15:0] cnt_q;
  assign busy = (left_q != 4'h0);
  // Each edge follows the previous one by gap plus one cycles, then the line rests.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rx_line <= 1'b0;
      left_q  <= 4'h0;
      cnt_q   <= 16'h0000;
    end else if (go) begin
      left_q <= n_edges;
      cnt_q  <= 16'h0000;
    end else if (left_q != 4'h0) begin
      if (cnt_q == gap) begin
        rx_line <= ~rx_line;
        left_q  <= left_q - 4'h1;
        cnt_q   <= 16'h0000;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end
endmodule

// ### verif/tb.sv
// Self-checking bench for the line coder timing block.
`timescale 1ns/1ns
module tb;
  logic        sys_clk;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_line;
  logic [7:0]  rx_hi_max;
  logic [7:0]  rx_lo_max;
  logic        squelch_active;
  logic        rx_path_open;
  logic        line_active;
  logic        tx_bit_valid;
  logic        tx_bit;
  logic        tx_bit_ready;
  logic        tx_line;
  logic        tx_line_oe_n;
  logic        tx_busy;
  logic        go;
  logic [3:0]  n_edges;
  logic [15:0] gap;
  logic        rp_busy;
  logic        sq_seen;
  logic        act_seen;
  logic        busy_prev;
  logic        line_prev;
  logic        refused;
  logic        err;
  logic [31:0] rd;
  int          n_errors;
  int          checks_done;
  int          cyc;
  int          tog;
  int          busy_cyc;
  int          oe_bad;
  int          n;
  int          m;
  int          gaps [3] = '{60, 130, 150};
  logic        sq_exp [3] = '{1'b1, 1'b1, 1'b0};
  int          drop_exp [3] = '{206, 186, 0};

  bst_top bst_top_i (
    .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_line(rx_line), .rx_hi_max_time(rx_hi_max), .rx_lo_max_time(rx_lo_max),
    .squelch_active(squelch_active), .rx_path_open(rx_path_open), .line_active(line_active),
    .tx_bit_valid(tx_bit_valid), .tx_bit(tx_bit), .tx_bit_ready(tx_bit_ready),
    .tx_line(tx_line), .tx_line_oe_n(tx_line_oe_n), .tx_busy(tx_busy)
  );
  bst_remote_port bst_remote_port_i (
    .sys_clk(sys_clk), .nrst(nrst), .go(go), .n_edges(n_edges), .gap(gap),
    .rx_line(rx_line), .busy(rp_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Watches the outputs between edges and cuts a hang short.
  always @(negedge sys_clk) begin
    cyc++;
    if (squelch_active === 1'b1) sq_seen = 1'b1;
    if (line_active === 1'b1) act_seen = 1'b1;
    if (tx_busy === 1'b1) begin
      busy_cyc++;
      if (tx_line_oe_n !== 1'b0) oe_bad++;
      if (busy_prev && tx_line !== line_prev) tog++;
    end
    busy_prev = (tx_busy === 1'b1);
    line_prev = tx_line;
    if (tx_bit_ready === 1'b0 && tx_bit_valid) refused = 1'b1;
    if (cyc > 30000) begin
      n_errors++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task burst(input logic [3:0] cnt, input logic [15:0] g);
    @(posedge sys_clk);
    go      <= 1'b1;
    n_edges <= cnt;
    gap     <= g;
    @(posedge sys_clk);
    go <= 1'b0;
    @(posedge sys_clk);
    while (rp_busy) @(posedge sys_clk);
  endtask

  task push(input logic b);
    @(posedge sys_clk);
    tx_bit_valid <= 1'b1;
    tx_bit       <= b;
    @(posedge sys_clk);
    while (tx_bit_ready !== 1'b1) @(posedge sys_clk);
    tx_bit_valid <= 1'b0;
  endtask

  task tx_wait();
    n = 0;
    while (tx_busy !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    while (tx_busy === 1'b1 && n < 900) begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  task end_sim();
    $display("Checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst         = 1'b0;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 16'h0000;
    pwdata       = 32'h0000_0000;
    rx_hi_max    = 8'hC8;
    rx_lo_max    = 8'hB4;
    tx_bit_valid = 1'b0;
    tx_bit       = 1'b0;
    go           = 1'b0;
    n_edges      = 4'h0;
    gap          = 16'h0000;
    n_errors     = 0;
    checks_done  = 0;
    cyc          = 0;
    tog          = 0;
    busy_cyc     = 0;
    oe_bad       = 0;
    sq_seen      = 1'b0;
    act_seen     = 1'b0;
    busy_prev    = 1'b0;
    line_prev    = 1'b0;
    refused      = 1'b0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    // Reset values, read and write of each field, and an unmapped place.
    for (int i = 0; i < bst_pkg::NREG; i++) begin
      apb(1'b0, bst_pkg::REG_ADDR[i], 32'h0000_0000);
      chk("reset value", rd, 32'h0000_0000);
      apb(1'b1, bst_pkg::REG_ADDR[i], 32'hFFFF_FF5A);
      apb(1'b0, bst_pkg::REG_ADDR[i], 32'h0000_0000);
      chk("readback", rd, 32'h0000_005A);
    end
    apb(1'b0, 16'h0010, 32'h0000_0000);
    chk("unmapped error", {31'h0, err}, 32'h0000_0001);
    chk("unmapped data", rd, 32'h0000_0000);
    apb(1'b1, bst_pkg::REG_ADDR[bst_pkg::RI_SQ_ASSERT], 32'h0000_0046);
    apb(1'b1, bst_pkg::REG_ADDR[bst_pkg::RI_SQ_HOLD], 32'h0000_0017);
    apb(1'b1, bst_pkg::REG_ADDR[bst_pkg::RI_IDLE_WIN], 32'h0000_00C8);
    apb(1'b1, bst_pkg::REG_ADDR[bst_pkg::RI_TX_PERIOD], 32'h0000_000F);
    // Edge bursts inside, near and beyond the assert window of 281 cycles.
    // The bursts leave the line high, then low, so both bit time limits are used.
    for (int k = 0; k < 3; k++) begin
      sq_seen = 1'b0;
      act_seen = 1'b0;
      burst(4'h5, gaps[k][15:0]);
      chk("squelch", {31'h0, sq_seen}, {31'h0, sq_exp[k]});
      chk("line active", {31'h0, act_seen}, 32'h0000_0001);
      if (sq_exp[k]) begin
        n = 0;
        while (squelch_active === 1'b1 && n < 400) begin
          @(posedge sys_clk);
          n++;
        end
        chk("drop delay", n, drop_exp[k]);
        m = 0;
        while (rx_path_open === 1'b1 && m < 400) begin
          @(posedge sys_clk);
          m++;
        end
        chk("hold time", m, 93);
      end
      repeat (300) @(posedge sys_clk);
    end
    n = 0;
    while (line_active === 1'b1 && n < 1700) begin
      @(posedge sys_clk);
      n++;
    end
    chk("line idle", {31'h0, line_active}, 32'h0000_0000);
    // Four bits back to back fill the buffer while the encoder is busy.
    busy_cyc = 0;
    tog = 0;
    for (int b = 3; b >= 0; b--) push(b != 1);
    tx_wait();
    chk("busy cycles", busy_cyc, 64);
    chk("toggles", tog, 6);
    chk("refused", {31'h0, refused}, 32'h0000_0001);
    chk("oe low in bit", oe_bad, 0);
    chk("oe after", {31'h0, tx_line_oe_n}, 32'h0000_0001);
    apb(1'b1, bst_pkg::REG_ADDR[bst_pkg::RI_TX_PERIOD], 32'h0000_009F);
    busy_cyc = 0;
    push(1'b0);
    tx_wait();
    chk("nominal bit", busy_cyc, 160);
    end_sim();
  end
endmodule
